// File: rfs_fault_status.sv
`timescale 1ns/1ps
`default_nettype none

module rfs_fault_status #(
  parameter int NUM_RECORDS = 8,
  parameter bit HAS_QUEUED_INV = 1'b1,
  parameter bit HAS_DEV_TLB = 1'b1,
  parameter bit HAS_ADV_LOG = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire rfs_pkg::rfs_fault_s FAULT_IN,
  output logic FAULT_ACCEPT,
  input wire logic [NUM_RECORDS-1:0] RECORD_CLEAR,
  input wire rfs_pkg::rfs_events_s EVENTS_IN,
  output logic FAULT_EVENT,
  output logic [NUM_RECORDS-1:0] RECORD_FLAGS,
  output logic IRQ
);

  // The record flags and the index field share the 8-bit index space.
  if (NUM_RECORDS < 1 || NUM_RECORDS > 256) begin : g_bad_records
    $error("NUM_RECORDS must lie between 1 and 256");
  end

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [NUM_RECORDS-1:0] flags;
    logic [7:0] rec_idx;
    logic pri_ovf;
    logic adv_ovf;
    logic adv_pend;
    logic queue_err;
    logic compl_err;
    logic timeout_err;
    logic event_pulse;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic [31:0] rdata;
  } rfs_state_s;

  rfs_state_s st_reg;
  rfs_state_s st_next;

  ////////////////////////////////////////////////////////////////////////////

  logic access;
  logic wr;
  logic fs_wr;
  logic [31:0] status_word;
  logic pri_pend;
  logic any_set;
  logic new_flag;
  logic [NUM_RECORDS-1:0] set_mask;
  logic [NUM_RECORDS-1:0] hit_mask;
  logic [31:0] rd_mux;
  logic mapped;
  logic clr_pri_ovf;
  logic overflow;
  logic pend_rise;
  logic ev_adv_pend;
  logic ev_adv_ovf;
  logic ev_queue_err;
  logic ev_compl_err;
  logic ev_timeout_err;

  assign access = PSEL && PENABLE;
  assign wr = access && PWRITE;
  assign fs_wr = wr && PADDR == rfs_pkg::FAULT_STATUS_OFF;

  ////////////////////////////////////////////////////////////////////////////

  // Read data is picked in the setup cycle so that it comes from a flop.
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      rfs_pkg::FAULT_STATUS_OFF: rd_mux = status_word;
      rfs_pkg::IRQ_STATUS_OFF: rd_mux = {30'h0, st_reg.irq_status};
      rfs_pkg::IRQ_CLEAR_OFF: rd_mux = 32'h0000_0000;
      rfs_pkg::IRQ_ENABLE_OFF: rd_mux = {30'h0, st_reg.irq_enable};
      rfs_pkg::RECORD_FLAGS_OFF: rd_mux = 32'(st_reg.flags);
      default: mapped = 1'b0;
    endcase
  end

  assign pri_pend = |st_reg.flags;

  always_comb begin
    status_word = rfs_pkg::FAULT_STATUS_RESET;
    status_word[rfs_pkg::REC_IDX_MSB:rfs_pkg::REC_IDX_LSB] = st_reg.rec_idx;
    status_word[rfs_pkg::PRI_PEND_BIT] = pri_pend;
    status_word[rfs_pkg::PRI_OVF_BIT] = st_reg.pri_ovf;
    status_word[rfs_pkg::ADV_OVF_BIT] = st_reg.adv_ovf && HAS_ADV_LOG;
    status_word[rfs_pkg::ADV_PEND_BIT] = st_reg.adv_pend && HAS_ADV_LOG;
    status_word[rfs_pkg::QUEUE_ERR_BIT] = st_reg.queue_err && HAS_QUEUED_INV;
    status_word[rfs_pkg::COMPL_ERR_BIT] = st_reg.compl_err && HAS_DEV_TLB;
    status_word[rfs_pkg::TIMEOUT_ERR_BIT] = st_reg.timeout_err && HAS_DEV_TLB;
  end

  ////////////////////////////////////////////////////////////////////////////

  assign FAULT_ACCEPT = !st_reg.pri_ovf;

  genvar g;
  generate
    for (g = 0; g < NUM_RECORDS; g++) begin : g_rec
      assign hit_mask[g] = FAULT_IN.index == 8'(g);
      assign set_mask[g] = FAULT_IN.valid && FAULT_ACCEPT && !st_reg.flags[g] && hit_mask[g];
    end
  endgenerate

  // A fault aimed at a record still pending, or past the last one, overflows.
  assign overflow = FAULT_IN.valid && FAULT_ACCEPT &&
                    ((32'(FAULT_IN.index) >= NUM_RECORDS) || (|(hit_mask & st_reg.flags)));
  assign pend_rise = !pri_pend && (|set_mask);
  assign any_set = |status_word[rfs_pkg::TIMEOUT_ERR_BIT:rfs_pkg::PRI_OVF_BIT];
  assign clr_pri_ovf = fs_wr && PWDATA[rfs_pkg::PRI_OVF_BIT];

  assign ev_adv_pend = HAS_ADV_LOG && EVENTS_IN.adv_first_record && !st_reg.adv_pend;
  assign ev_adv_ovf = HAS_ADV_LOG && EVENTS_IN.adv_overflow && !st_reg.adv_ovf;
  assign ev_queue_err = HAS_QUEUED_INV && EVENTS_IN.queue_error && !st_reg.queue_err;
  assign ev_compl_err = HAS_DEV_TLB && EVENTS_IN.completion_error && !st_reg.compl_err;
  assign ev_timeout_err = HAS_DEV_TLB && EVENTS_IN.completion_timeout && !st_reg.timeout_err;

  assign new_flag = pend_rise || ev_adv_pend || ev_adv_ovf || ev_queue_err ||
                    ev_compl_err || ev_timeout_err;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next = st_reg;

    st_next.flags = (st_reg.flags & ~RECORD_CLEAR) | set_mask;
    if (pend_rise) begin
      st_next.rec_idx = FAULT_IN.index;
    end

    if (clr_pri_ovf) begin
      st_next.pri_ovf = 1'b0;
    end
    if (overflow) begin
      st_next.pri_ovf = 1'b1;
    end

    if (fs_wr && PWDATA[rfs_pkg::ADV_PEND_BIT]) begin
      st_next.adv_pend = 1'b0;
    end
    if (fs_wr && PWDATA[rfs_pkg::ADV_OVF_BIT]) begin
      st_next.adv_ovf = 1'b0;
    end
    if (fs_wr && PWDATA[rfs_pkg::QUEUE_ERR_BIT]) begin
      st_next.queue_err = 1'b0;
    end
    if (fs_wr && PWDATA[rfs_pkg::COMPL_ERR_BIT]) begin
      st_next.compl_err = 1'b0;
    end
    if (fs_wr && PWDATA[rfs_pkg::TIMEOUT_ERR_BIT]) begin
      st_next.timeout_err = 1'b0;
    end
    // Sets follow the clears, but an event only sets a flag that was clear, so an event meeting a same-cycle clear of its set flag is lost.
    // Event flag sets: first record, advanced overflow, queue, completion and timeout errors.
    if (ev_adv_pend) begin
      st_next.adv_pend = 1'b1;
    end
    if (ev_adv_ovf) begin
      st_next.adv_ovf = 1'b1;
    end
    if (ev_queue_err) begin
      st_next.queue_err = 1'b1;
    end
    if (ev_compl_err) begin
      st_next.compl_err = 1'b1;
    end
    if (ev_timeout_err) begin
      st_next.timeout_err = 1'b1;
    end

    st_next.event_pulse = new_flag && !any_set;

    if (wr && PADDR == rfs_pkg::IRQ_CLEAR_OFF) begin
      st_next.irq_status = st_reg.irq_status & ~PWDATA[1:0];
    end
    if (wr && PADDR == rfs_pkg::IRQ_ENABLE_OFF) begin
      st_next.irq_enable = PWDATA[1:0];
    end
    if (st_reg.event_pulse) begin
      st_next.irq_status[rfs_pkg::IRQ_EVENT_BIT] = 1'b1;
    end
    if (FAULT_IN.valid && !FAULT_ACCEPT) begin
      st_next.irq_status[rfs_pkg::IRQ_DROP_BIT] = 1'b1;
    end

    if (PSEL && !PENABLE && !PWRITE) begin
      st_next.rdata = rd_mux;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
      st_reg.irq_enable <= rfs_pkg::IRQ_ENABLE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;
  assign PRDATA = st_reg.rdata;
  assign FAULT_EVENT = st_reg.event_pulse;
  assign RECORD_FLAGS = st_reg.flags;
  assign IRQ = |(st_reg.irq_status & st_reg.irq_enable);

endmodule

`default_nettype wire

// File: rfs_pkg.sv
`default_nettype none

package rfs_pkg;

  localparam logic [11:0] FAULT_STATUS_OFF = 12'h034;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h040;
  localparam logic [11:0] IRQ_CLEAR_OFF = 12'h044;
  localparam logic [11:0] IRQ_ENABLE_OFF = 12'h048;
  localparam logic [11:0] RECORD_FLAGS_OFF = 12'h04C;

  localparam int PRI_OVF_BIT = 0;
  localparam int PRI_PEND_BIT = 1;
  localparam int ADV_OVF_BIT = 2;
  localparam int ADV_PEND_BIT = 3;
  localparam int QUEUE_ERR_BIT = 4;
  localparam int COMPL_ERR_BIT = 5;
  localparam int TIMEOUT_ERR_BIT = 6;
  localparam int REC_IDX_LSB = 8;
  localparam int REC_IDX_MSB = 15;

  localparam logic [31:0] FAULT_STATUS_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;

  // Interrupt status bit 0 is the fault event, bit 1 a discarded fault.
  localparam int IRQ_EVENT_BIT = 0;
  localparam int IRQ_DROP_BIT = 1;

  typedef struct packed {
    logic valid;
    logic [7:0] index;
  } rfs_fault_s;

  typedef struct packed {
    logic adv_first_record;
    logic adv_overflow;
    logic queue_error;
    logic completion_error;
    logic completion_timeout;
  } rfs_events_s;

endpackage

`default_nettype wire

// File: rfs_fault_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_fault_status_chk #(parameter int NUM_RECORDS = 8) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire rfs_pkg::rfs_fault_s FAULT_IN,
  input wire logic FAULT_ACCEPT,
  input wire rfs_pkg::rfs_events_s EVENTS_IN,
  input wire logic FAULT_EVENT,
  input wire logic [NUM_RECORDS-1:0] RECORD_FLAGS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic acc, rd, wr, fv;
  assign acc = PSEL && PENABLE && PADDR == rfs_pkg::FAULT_STATUS_OFF;
  assign rd = acc && !PWRITE;
  assign wr = acc && PWRITE;
  assign fv = FAULT_IN.valid && FAULT_ACCEPT;
  property p_rec; fv && FAULT_IN.index < NUM_RECORDS |=> RECORD_FLAGS[$past(FAULT_IN.index)];
  endproperty
  a_rec: assert property (p_rec) else $error("fault not recorded");
  property p_block; !FAULT_ACCEPT |=> (RECORD_FLAGS & ~$past(RECORD_FLAGS)) == '0; endproperty
  a_block: assert property (p_block) else $error("record while blocked");
  property p_pending; rd |-> PRDATA[1] == ($past(RECORD_FLAGS) != '0); endproperty
  a_pending: assert property (p_pending) else $error("pending bit wrong");
  property p_rsvd; rd |-> PRDATA[31:16] == 16'h0000 && !PRDATA[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_evt; FAULT_EVENT |-> $past(FAULT_IN.valid) || $past(EVENTS_IN) != '0;
  endproperty
  a_evt: assert property (p_evt) else $error("event without cause");
  property p_ovf; fv && FAULT_IN.index >= NUM_RECORDS |=> !FAULT_ACCEPT; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not set");
  property p_w1c; wr && PWDATA[0] && !FAULT_IN.valid |=> FAULT_ACCEPT; endproperty
  a_w1c: assert property (p_w1c) else $error("overflow not cleared");
  property p_w0; wr && !PWDATA[0] && !FAULT_ACCEPT |=> !FAULT_ACCEPT; endproperty
  a_w0: assert property (p_w0) else $error("overflow lost");
endmodule
`default_nettype wire

// File: rfs_fault_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_fault_status_tb_top;
  logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic PREADY, PSLVERR, FAULT_ACCEPT, FAULT_EVENT, IRQ, err;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic [7:0] RECORD_CLEAR = '0, RECORD_FLAGS;
  rfs_pkg::rfs_fault_s FAULT_IN = '0;
  rfs_pkg::rfs_events_s EVENTS_IN = '0;
  int mismatches = 0, comparisons = 0, nev = 0;
  rfs_fault_status #(.NUM_RECORDS(8)) dut (.CLOCK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FAULT_IN, .FAULT_ACCEPT, .RECORD_CLEAR, .EVENTS_IN,
    .FAULT_EVENT, .RECORD_FLAGS, .IRQ);
  initial forever #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (FAULT_EVENT === 1'b1) nev <= nev + 1;
  task summarize;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLOCK); PENABLE <= 1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    rd = PRDATA; err = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
    @(posedge CLOCK);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0); chk(rd & m, e);
  endtask
  task pulse(input logic [7:0] i, input logic [4:0] ev, input logic [7:0] clr);
    FAULT_IN <= '{i != 8'hFF, i}; EVENTS_IN <= ev; RECORD_CLEAR <= clr;
    @(posedge CLOCK); FAULT_IN <= '0; EVENTS_IN <= '0; RECORD_CLEAR <= '0;
    repeat (3) @(posedge CLOCK);
  endtask
  task t_reset;
    rdc(12'h034, 32'hFFFFFFFF, 32'h0);
    rdc(12'h040, 32'hFFFFFFFF, 32'h0);
    rdc(12'h048, 32'hFFFFFFFF, 32'h0);
    apb(0, 12'h050, 0); chk(err, 1);
  endtask
  task t_fault;
    pulse(8'h03, 0, 0); chk(nev, 1);
    chk(RECORD_FLAGS, 8'h08);
    rdc(12'h034, 32'hFFFFFFFF, 32'h302);
    pulse(8'h05, 0, 0); chk(nev, 1);
    rdc(12'h034, 32'hFFFFFFFF, 32'h302);
    rdc(12'h04C, 32'hFF, 32'h28);
    apb(1, 12'h048, 1); chk(IRQ, 1);
    apb(1, 12'h048, 0); chk(IRQ, 0);
    apb(1, 12'h044, 1); rdc(12'h040, 32'h3, 0);
    pulse(8'hFF, 0, 8'hFF); rdc(12'h034, 32'hFFFF00FF, 0);
  endtask
  task t_ovf;
    int n0;
    pulse(8'h09, 0, 0); rdc(12'h034, 32'hFF, 1);
    chk(FAULT_ACCEPT, 0);
    pulse(8'h02, 0, 0); chk(RECORD_FLAGS, 0);
    rdc(12'h040, 32'h3, 32'h2);
    apb(1, 12'h044, 2);
    apb(1, 12'h034, 0); rdc(12'h034, 32'hFF, 1);
    apb(1, 12'h034, 1); chk(FAULT_ACCEPT, 1);
    n0 = nev;
    pulse(8'h06, 0, 0); rdc(12'h034, 32'hFFFF, 32'h602);
    chk(nev, n0 + 1);
    pulse(8'hFF, 0, 8'hFF);
  endtask
  task t_events;
    logic [31:0] exp [5] = '{32'h40, 32'h20, 32'h10, 32'h04, 32'h08};
    int n0;
    for (int i = 0; i < 5; i++) begin
      n0 = nev;
      pulse(8'hFF, 5'h1 << i, 0); rdc(12'h034, 32'hFFFF00FF, exp[i]);
      chk(nev, n0 + 1);
      apb(1, 12'h034, rd); rdc(12'h034, 32'hFFFF00FF, 0);
    end
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    RST_N <= 1;
    @(posedge CLOCK);
    t_reset; t_fault; t_ovf; t_events;
    summarize;
  end
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule
bind rfs_fault_status rfs_fault_status_chk #(.NUM_RECORDS(NUM_RECORDS)) u_chk (.CLOCK, .RST_N,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .FAULT_IN, .FAULT_ACCEPT, .EVENTS_IN,
  .FAULT_EVENT, .RECORD_FLAGS);
`default_nettype wire
